// ### rtl/trc_top.sv
// torque reference conditioner: direction, two first-order filters, limiter
// assumes one 20 MHz clock, synchronous active-low reset, digital
// inputs from pins (synchronised here), analog torques already scaled
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`include "trc_regs.svh"

module trc_top
    import trc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire trc_bus_t    bus_i,
    input  wire trc_din_t    din_i,
    output logic [15:0]      rdata_o,
    output trc_torque_t      torque_o,
    output logic             limited_o,
    output logic             rotation_cw_o
);

    // configuration registers
    logic [15:0]  ctrl_ff;
    logic [15:0]  tf1_ff;
    logic [15:0]  tf2_ff;
    logic [15:0]  int_pos_ff;
    logic [15:0]  int_neg_ff;
    logic [15:0]  ext_pos_ff;
    logic [15:0]  ext_neg_ff;
    trc_torque_t  ref_in_ff;
    trc_torque_t  an_one_ff;
    trc_torque_t  an_two_ff;
    logic [15:0]  rdata_ff;

    // synchronisers for the four pin inputs
    trc_din_t     din_s1_ff;
    trc_din_t     din_s2_ff;

    // filter state, widened for fractional accuracy
    logic signed [31:0] filt_ff;
    logic [7:0]   step_cnt_ff;
    trc_torque_t  out_ff;
    logic         limited_ff;
    logic         cw_ff;

    function automatic logic [15:0] sat_lim(input logic [15:0] v);
        sat_lim = (v > `TRC_LIM_MAX) ? `TRC_LIM_MAX : v;
    endfunction : sat_lim

    function automatic logic [15:0] sat_tf(input logic [15:0] v);
        sat_tf = (v > `TRC_TF_MAX) ? `TRC_TF_MAX : v;
    endfunction : sat_tf

    function automatic logic [15:0] mag(input trc_torque_t v);
        mag = v[15] ? 16'(-v) : 16'(v);
    endfunction : mag

    function automatic logic [15:0] min16(input logic [15:0] a,
                                          input logic [15:0] b);
        min16 = (a < b) ? a : b;
    endfunction : min16

    // register writes; limits and time constants saturate on entry
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ctrl_ff    <= `TRC_CTRL_RST;
            tf1_ff     <= `TRC_TF_RST;
            tf2_ff     <= `TRC_TF_RST;
            int_pos_ff <= `TRC_LIM_RST;
            int_neg_ff <= `TRC_LIM_RST;
            ext_pos_ff <= `TRC_LIM_RST;
            ext_neg_ff <= `TRC_LIM_RST;
            ref_in_ff  <= 16'sh0000;
            an_one_ff  <= 16'sh0000;
            an_two_ff  <= 16'sh0000;
        end else if (bus_i.wr) begin
            unique case (bus_i.addr)
                `TRC_OFS_CTRL:    ctrl_ff    <= bus_i.wdata;
                `TRC_OFS_TF1:     tf1_ff     <= sat_tf(bus_i.wdata);
                `TRC_OFS_TF2:     tf2_ff     <= sat_tf(bus_i.wdata);
                `TRC_OFS_INT_POS: int_pos_ff <= sat_lim(bus_i.wdata);
                `TRC_OFS_INT_NEG: int_neg_ff <= sat_lim(bus_i.wdata);
                `TRC_OFS_EXT_POS: ext_pos_ff <= sat_lim(bus_i.wdata);
                `TRC_OFS_EXT_NEG: ext_neg_ff <= sat_lim(bus_i.wdata);
                `TRC_OFS_REF_IN:  ref_in_ff  <= bus_i.wdata;
                `TRC_OFS_AN_ONE:  an_one_ff  <= bus_i.wdata;
                `TRC_OFS_AN_TWO:  an_two_ff  <= bus_i.wdata;
                default: ;
            endcase
        end
    end

    // control fields
    logic       dir_param;
    logic       gain_en;
    logic [2:0] src_sel;
    logic [1:0] chan_sel;
    logic [3:0] gain_cond;
    assign dir_param = ctrl_ff[`TRC_CTRL_DIR_BIT];
    assign gain_en   = ctrl_ff[`TRC_CTRL_GSE_BIT];
    assign src_sel   = ctrl_ff[`TRC_CTRL_SRC_LSB +: 3];
    assign chan_sel  = ctrl_ff[`TRC_CTRL_CHAN_LSB +: 2];
    assign gain_cond = ctrl_ff[`TRC_CTRL_COND_LSB +: 4];

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            din_s1_ff <= '0;
            din_s2_ff <= '0;
        end else begin
            din_s1_ff <= din_i;
            din_s2_ff <= din_s1_ff;
        end
    end

    // direction: inactive select means reverse, so the sign flips
    trc_torque_t dir_ref;
    assign dir_ref = din_s2_ff.dir_sel ? ref_in_ff
                                       : 16'(-ref_in_ff);

    // filter selection and time base
    logic        use_second;
    logic [15:0] tf_sel;
    assign use_second = gain_en && (gain_cond != 4'h0)
                        && din_s2_ff.gain_cond;
    assign tf_sel = use_second ? tf2_ff : tf1_ff;

    logic step;
    assign step = (step_cnt_ff == 8'(`TRC_STEP_CYC - 1));

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || step) begin
            step_cnt_ff <= 8'h00;
        end else begin
            step_cnt_ff <= step_cnt_ff + 8'h01;
        end
    end

    // y += (x - y) / (n + 1), one step per 10 us where n = tc / 10 us;
    // a divider is traded for simplicity of one first-order response
    logic signed [31:0] err;
    logic signed [31:0] nxt_filt;
    logic [15:0]        tau_steps;
    assign tau_steps = tf_sel + 16'h0001;
    // both arms signed, else a falling step would divide unsigned
    assign err = $signed({dir_ref, 16'h0000}) - filt_ff;
    assign nxt_filt = (tf_sel == 16'h0000) ? $signed({dir_ref, 16'h0000})
                      : filt_ff + err / $signed({16'h0000, tau_steps});

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            filt_ff <= 32'sh0;
        end else if (step || tf_sel == 16'h0000) begin
            filt_ff <= nxt_filt;
        end
    end

    trc_torque_t filt_out;
    assign filt_out = filt_ff[31:16];

    // limit source per direction
    logic [15:0] an_lim;
    logic [15:0] pos_lim;
    logic [15:0] neg_lim;
    assign an_lim = sat_lim(mag((chan_sel == 2'h1) ? an_one_ff
                                                   : an_two_ff));

    always_comb begin
        pos_lim = int_pos_ff;
        neg_lim = int_neg_ff;
        unique case (src_sel)
            3'h0: begin
                pos_lim = int_pos_ff;
                neg_lim = int_neg_ff;
            end
            3'h1: begin
                pos_lim = din_s2_ff.pos_sel ? ext_pos_ff : int_pos_ff;
                neg_lim = din_s2_ff.neg_sel ? ext_neg_ff : int_neg_ff;
            end
            3'h2: begin
                pos_lim = an_lim;
                neg_lim = an_lim;
            end
            3'h3: begin
                pos_lim = din_s2_ff.pos_sel ? min16(ext_pos_ff, an_lim)
                                            : an_lim;
                neg_lim = din_s2_ff.neg_sel ? min16(ext_neg_ff, an_lim)
                                            : an_lim;
            end
            3'h4: begin
                pos_lim = din_s2_ff.pos_sel ? an_lim : int_pos_ff;
                neg_lim = din_s2_ff.neg_sel ? an_lim : int_neg_ff;
            end
            default: begin
                pos_lim = int_pos_ff;
                neg_lim = int_neg_ff;
            end
        endcase
    end

    // clamp
    logic        over;
    trc_torque_t nxt_out;
    logic [15:0] act_lim;
    assign act_lim = filt_out[15] ? neg_lim : pos_lim;
    assign over = mag(filt_out) > act_lim;
    assign nxt_out = !over ? filt_out
                     : (filt_out[15] ? 16'(-act_lim) : act_lim);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            out_ff     <= 16'sh0000;
            limited_ff <= 1'b0;
        end else begin
            out_ff     <= nxt_out;
            limited_ff <= over;
        end
    end

    // clockwise when the parameter xor reference sign xor select is set
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cw_ff <= 1'b0;
        end else begin
            cw_ff <= dir_param ^ ref_in_ff[15] ^ din_s2_ff.dir_sel;
        end
    end

    // read port
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_ff <= 16'h0000;
        end else if (bus_i.rd) begin
            unique case (bus_i.addr)
                `TRC_OFS_CTRL:    rdata_ff <= ctrl_ff;
                `TRC_OFS_TF1:     rdata_ff <= tf1_ff;
                `TRC_OFS_TF2:     rdata_ff <= tf2_ff;
                `TRC_OFS_INT_POS: rdata_ff <= int_pos_ff;
                `TRC_OFS_INT_NEG: rdata_ff <= int_neg_ff;
                `TRC_OFS_EXT_POS: rdata_ff <= ext_pos_ff;
                `TRC_OFS_EXT_NEG: rdata_ff <= ext_neg_ff;
                `TRC_OFS_REF_IN:  rdata_ff <= ref_in_ff;
                `TRC_OFS_AN_ONE:  rdata_ff <= an_one_ff;
                `TRC_OFS_AN_TWO:  rdata_ff <= an_two_ff;
                `TRC_OFS_REF_OUT: rdata_ff <= out_ff;
                `TRC_OFS_STATUS:  rdata_ff <= {13'h0000, use_second,
                                               cw_ff, limited_ff};
                default:          rdata_ff <= 16'h0000;
            endcase
        end
    end

    assign rdata_o       = rdata_ff;
    assign torque_o      = out_ff;
    assign limited_o     = limited_ff;
    assign rotation_cw_o = cw_ff;

    // checks; a tag sits on the line of its label
    limit_cap_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i) mag(out_ff) <= `TRC_LIM_MAX)
        else $error("output above cap");
    flag_match_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i) over |=> limited_o)
        else $error("limit flag missing");
    clamp_value_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i) !over |=> torque_o == $past(filt_out))
        else $error("pass-through altered");
    src_zero_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i) src_sel == 3'h0
        |-> pos_lim == int_pos_ff && neg_lim == int_neg_ff)
        else $error("selector 0 wrong limit");
    src_four_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i) src_sel == 3'h4 && din_s2_ff.pos_sel
        |-> pos_lim == an_lim)
        else $error("selector 4 wrong limit");
    src_three_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i) src_sel == 3'h3
        |-> pos_lim <= an_lim && neg_lim <= an_lim)
        else $error("selector 3 above analog");
    second_filt_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i) !gain_en |-> tf_sel == tf1_ff)
        else $error("second filter misused");
    dir_flip_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i) $changed(din_s2_ff.dir_sel)
        && $stable(ref_in_ff) && $stable(dir_param)
        |=> $changed(rotation_cw_o))
        else $error("rotation not reversed");

    // a clamped output carries the limit of its own sign
    sequence pos_over_s;
        !filt_out[15] && (mag(filt_out) > pos_lim);
    endsequence : pos_over_s
    sequence neg_over_s;
        filt_out[15] && (mag(filt_out) > neg_lim);
    endsequence : neg_over_s
    clamp_pos_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        pos_over_s |=> torque_o == $past(pos_lim) && limited_o)
        else $error("positive clamp wrong");
    clamp_neg_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        neg_over_s |=> torque_o == 16'h0000 - $past(neg_lim) && limited_o)
        else $error("negative clamp wrong");
    flag_clear_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i) !over |=> !limited_o)
        else $error("flag without clamp");

    // a select pin reaches the limit logic two edges after it moves
    sequence sel_rise_s;
        $rose(din_i.pos_sel) ##1 din_s1_ff.pos_sel;
    endsequence : sel_rise_s
    pin_sync_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i) sel_rise_s |=> din_s2_ff.pos_sel)
        else $error("limit select not synchronised");
    dir_rev_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i) !din_s2_ff.dir_sel
        |-> dir_ref == 16'h0000 - ref_in_ff)
        else $error("reverse direction not negated");

    // limit sources that the tests above leave unguarded
    src_one_pos_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i) src_sel == 3'h1 && din_s2_ff.pos_sel
        |-> pos_lim == ext_pos_ff)
        else $error("selector 1 wrong positive limit");
    src_one_neg_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i) src_sel == 3'h1 && !din_s2_ff.neg_sel
        |-> neg_lim == int_neg_ff)
        else $error("selector 1 wrong negative limit");
    src_two_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i) src_sel == 3'h2
        |-> pos_lim == an_lim && neg_lim == an_lim)
        else $error("selector 2 not analog");
    src_three_neg_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i) src_sel == 3'h3 && !din_s2_ff.neg_sel
        |-> neg_lim == an_lim)
        else $error("selector 3 wrong negative limit");
    src_four_neg_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i) src_sel == 3'h4 && !din_s2_ff.neg_sel
        |-> neg_lim == int_neg_ff)
        else $error("selector 4 wrong negative limit");
    single_source_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i) src_sel > 3'h4
        |-> pos_lim == int_pos_ff && neg_lim == int_neg_ff)
        else $error("spare selector not internal");
    chan_default_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i) chan_sel != 2'h1
        |-> an_lim == sat_lim(mag(an_two_ff)))
        else $error("channel two not chosen");
    lim_range_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        pos_lim <= `TRC_LIM_MAX && neg_lim <= `TRC_LIM_MAX)
        else $error("limit above cap");

    // time constants stay in range and a zero constant passes straight on
    tc_one_range_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i) tf1_ff <= `TRC_TF_MAX)
        else $error("first time constant out of range");
    tc_two_range_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i) tf2_ff <= `TRC_TF_MAX)
        else $error("second time constant out of range");
    first_filter_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i) !din_s2_ff.gain_cond |-> tf_sel == tf1_ff)
        else $error("first filter not default");
    filter_pass_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i) tf_sel == 16'h0000
        |=> filt_out == $past(dir_ref))
        else $error("zero time constant not transparent");

endmodule : trc_top

// ### rtl/trc_regs.svh
// constants for the torque reference conditioner
// assumes a 20 MHz clock; torques in 0.1 percent units
`ifndef TRC_REGS_SVH
`define TRC_REGS_SVH
// register offsets on the plain register port
`define TRC_OFS_CTRL       4'h0
`define TRC_OFS_TF1        4'h1
`define TRC_OFS_TF2        4'h2
`define TRC_OFS_INT_POS    4'h3
`define TRC_OFS_INT_NEG    4'h4
`define TRC_OFS_EXT_POS    4'h5
`define TRC_OFS_EXT_NEG    4'h6
`define TRC_OFS_REF_IN     4'h7
`define TRC_OFS_AN_ONE     4'h8
`define TRC_OFS_AN_TWO     4'h9
`define TRC_OFS_REF_OUT    4'ha
`define TRC_OFS_STATUS     4'hb
// control field positions
`define TRC_CTRL_DIR_BIT   0
`define TRC_CTRL_GSE_BIT   1
`define TRC_CTRL_SRC_LSB   4
`define TRC_CTRL_CHAN_LSB  8
`define TRC_CTRL_COND_LSB  12
// reset values
`define TRC_CTRL_RST       16'h0200
`define TRC_TF_RST         16'h004f
`define TRC_LIM_RST        16'h0bb8
// limits in 0.1 percent and 0.01 ms
`define TRC_LIM_MAX        16'h0bb8
`define TRC_TF_MAX         16'h0bb8
// filter time base: one filter step per 10 us
`define TRC_STEP_NS        10000
`define TRC_CLK_NS         50
`define TRC_STEP_CYC       (`TRC_STEP_NS / `TRC_CLK_NS)
`endif

// ### rtl/trc_pkg.sv
// types of the torque reference conditioner
// assumes trc_regs.svh for all numeric constants
package trc_pkg;
    typedef logic signed [15:0] trc_torque_t;
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [3:0] addr;
        logic [15:0] wdata;
    } trc_bus_t;
    typedef struct packed {
        logic dir_sel;
        logic pos_sel;
        logic neg_sel;
        logic gain_cond;
    } trc_din_t;
endpackage : trc_pkg

// ### verification/trc_host_model.sv
// host controller model: register-port master and digital input pins
// assumes the conditioner samples every input on the rising clk_i edge
`timescale 1ns/10ps
module trc_host_model
    import trc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic [15:0] rdata_i,
    output trc_bus_t         bus_o,
    output trc_din_t         din_o
);
    initial begin
        bus_o = '0;
        din_o = '0;
    end
    // idle address and data are inverted so a stale value never helps
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk_i);
        bus_o <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
        @(posedge clk_i);
        bus_o <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~v};
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge clk_i);
        bus_o <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
        @(posedge clk_i);
        bus_o <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 16'hffff};
        #1 v = rdata_i;
    endtask : rd
    // limit-select functions sit on pins of their own
    task automatic pins(input trc_din_t p);
        @(posedge clk_i);
        din_o <= p;
    endtask : pins
endmodule : trc_host_model

// ### verification/test_torque_reference_conditioner.sv
// self-checking bench for the torque reference conditioner
// assumes trc_top and the host model; filter time constants set to 0 except in test_regs and test_filter
`timescale 1ns/10ps
`include "trc_regs.svh"
module test_torque_reference_conditioner
    import trc_pkg::*;
;
    logic        clk_i;
    logic        rst_n_i;
    trc_bus_t    bus;
    trc_din_t    din;
    logic [15:0] rdata;
    trc_torque_t torque;
    logic        limited;
    logic        cw;
    logic [15:0] d;
    int          mismatches = 0;
    int          tests_run = 0;
    int          cycles = 0;

    trc_top trc_top_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus_i(bus),
        .din_i(din), .rdata_o(rdata), .torque_o(torque),
        .limited_o(limited), .rotation_cw_o(cw));
    trc_host_model trc_host_model_i (.clk_i(clk_i), .rdata_i(rdata),
        .bus_o(bus), .din_o(din));

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    // whole run is near 50000 cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 90000) begin
            mismatches++;
            test_done();
        end
    end

    task automatic check(string n, logic [15:0] s, logic [15:0] e);
        tests_run++;
        if (s !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done
    function automatic logic [15:0] ctl(logic p, logic g, logic [2:0] src,
                                        logic [1:0] ch, logic [3:0] c);
        return {c, 2'b00, ch, 1'b0, src, 2'b00, g, p};
    endfunction : ctl
    // over two filter steps: long enough for pins, filter and output flops
    task automatic settle;
        repeat (450) @(posedge clk_i);
        #1;
    endtask : settle
    function automatic logic [15:0] exp_lim(logic [2:0] src, logic [1:0] ch,
                                            logic ng, logic sel);
        logic [15:0] an;
        logic [15:0] in;
        logic [15:0] ex;
        an = (ch == 2'h1) ? 16'h012c : 16'h0258;
        in = ng ? 16'h0320 : 16'h03e8;
        ex = ng ? 16'h0190 : 16'h01f4;
        case (src)
            3'h1: return sel ? ex : in;
            3'h2: return an;
            3'h3: return sel ? ((ex < an) ? ex : an) : an;
            3'h4: return sel ? an : in;
            default: return in;
        endcase
    endfunction : exp_lim

    task automatic test_regs;
        logic [3:0] a;
        trc_host_model_i.rd(`TRC_OFS_CTRL, d);
        check("ctrl_rst", d, 16'h0200);
        for (int i = 1; i < 7; i++) begin
            a = 4'(i);
            trc_host_model_i.rd(a, d);
            check("reg_rst", d, (i < 3) ? 16'h004f : 16'h0bb8);
        end
        trc_host_model_i.wr(`TRC_OFS_INT_POS, 16'h0fff);
        trc_host_model_i.rd(`TRC_OFS_INT_POS, d);
        check("lim_sat", d, 16'h0bb8);
        trc_host_model_i.wr(4'hc, 16'h1234);
        trc_host_model_i.rd(4'hc, d);
        check("unmapped", d, 16'h0000);
        trc_host_model_i.wr(`TRC_OFS_REF_OUT, 16'h0123);
        trc_host_model_i.rd(`TRC_OFS_REF_OUT, d);
        check("ro_out", d, 16'h0000);
        $display("test_regs done");
    endtask : test_regs

    task automatic status_bit2(logic e);
        settle();
        trc_host_model_i.rd(`TRC_OFS_STATUS, d);
        check("second_filter", {15'h0, d[2]}, {15'h0, e});
    endtask : status_bit2
    task automatic test_filter;
        trc_host_model_i.pins('{dir_sel: 1, pos_sel: 0, neg_sel: 0,
                                gain_cond: 1});
        trc_host_model_i.wr(`TRC_OFS_TF1, 16'h0064);
        trc_host_model_i.wr(`TRC_OFS_TF2, 16'h0000);
        trc_host_model_i.wr(`TRC_OFS_REF_IN, 16'h03e8);
        trc_host_model_i.wr(`TRC_OFS_CTRL, ctl(0, 1, 0, 2, 0));
        settle();
        check("filt_slow", {15'h0, torque > 0 && torque < 1000},
              16'h0001);
        status_bit2(0);
        trc_host_model_i.wr(`TRC_OFS_CTRL, ctl(0, 0, 0, 2, 1));
        status_bit2(0);
        trc_host_model_i.wr(`TRC_OFS_CTRL, ctl(0, 1, 0, 2, 1));
        status_bit2(1);
        check("filt_fast", torque, 16'h03e8);
        trc_host_model_i.pins('{dir_sel: 1, pos_sel: 0, neg_sel: 0,
                                gain_cond: 0});
        status_bit2(0);
        trc_host_model_i.wr(`TRC_OFS_REF_IN, 16'hfc18);
        settle();
        check("filt_fall", {15'h0, torque > 0 && torque < 1000},
              16'h0001);
        trc_host_model_i.wr(`TRC_OFS_CTRL, ctl(0, 0, 0, 2, 0));
        trc_host_model_i.wr(`TRC_OFS_TF1, 16'h0000);
        $display("test_filter done");
    endtask : test_filter

    task automatic test_dir;
        logic p;
        logic sg;
        logic dr;
        for (int i = 0; i < 8; i++) begin
            {dr, sg, p} = 3'(i);
            trc_host_model_i.wr(`TRC_OFS_CTRL, ctl(p, 0, 0, 2, 0));
            trc_host_model_i.pins('{dir_sel: dr, pos_sel: 0, neg_sel: 0,
                                    gain_cond: 0});
            trc_host_model_i.wr(`TRC_OFS_REF_IN, sg ? 16'hff38 : 16'h00c8);
            settle();
            check("cw", {15'h0, cw}, {15'h0, p ^ sg ^ dr});
            if (!p)
                check("dir_torque", torque,
                      (sg ^ ~dr) ? 16'hff38 : 16'h00c8);
            check("dir_limited", {15'h0, limited}, 16'h0000);
        end
        $display("test_dir done");
    endtask : test_dir

    task automatic test_limits;
        logic [2:0]  src;
        logic [1:0]  ch;
        logic [1:0]  s;
        logic        sg;
        logic [15:0] lim;
        trc_host_model_i.wr(`TRC_OFS_INT_POS, 16'h03e8);
        trc_host_model_i.wr(`TRC_OFS_INT_NEG, 16'h0320);
        trc_host_model_i.wr(`TRC_OFS_EXT_POS, 16'h01f4);
        trc_host_model_i.wr(`TRC_OFS_EXT_NEG, 16'h0190);
        trc_host_model_i.wr(`TRC_OFS_AN_ONE, 16'h012c);
        trc_host_model_i.wr(`TRC_OFS_AN_TWO, 16'hfda8);
        for (int i = 0; i < 96; i++) begin
            src = 3'(i / 16);
            ch = 2'(1 + ((i >> 3) & 1));
            s = 2'((i >> 1) & 3);
            sg = i[0];
            trc_host_model_i.wr(`TRC_OFS_CTRL, ctl(0, 0, src, ch, 0));
            trc_host_model_i.pins('{dir_sel: 1, pos_sel: s[0],
                                    neg_sel: s[1], gain_cond: 0});
            trc_host_model_i.wr(`TRC_OFS_REF_IN, sg ? 16'hf830 : 16'h07d0);
            settle();
            lim = exp_lim(src, ch, sg, s[sg]);
            check("lim_torque", torque,
                  sg ? 16'h0000 - lim : lim);
            check("lim_flag", {15'h0, limited}, 16'h0001);
        end
        $display("test_limits done");
    endtask : test_limits

    initial begin
        rst_n_i = 1'b0;
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        test_regs();
        test_filter();
        test_dir();
        test_limits();
        test_done();
    end
endmodule : test_torque_reference_conditioner
